/* inc/ptb_regs.vh */
`ifndef PTB_REGS_VH
`define PTB_REGS_VH

// register byte offsets, one aligned 32-bit word each
`define PTB_OFF_CTRL 8'h00
`define PTB_OFF_EV_STAT 8'h04
`define PTB_OFF_EV_CLR 8'h08
`define PTB_OFF_EV_EN 8'h0C
`define PTB_OFF_COUNT 8'h10
`define PTB_OFF_MODE 8'h14

// periodic_tick_control field positions
`define PTB_CTRL_RUN 1
`define PTB_CTRL_IE 2
`define PTB_CTRL_ACK 3
`define PTB_CTRL_RATE_LO 4
`define PTB_CTRL_RATE_HI 6
`define PTB_CTRL_PEND 7

// event status / clear / enable layout
`define PTB_EV_ROLL 0
`define PTB_EV_WAKE 1
`define PTB_EV_MISUSE 2
`define PTB_EV_W 3

// mode status layout
`define PTB_MODE_WAIT 0
`define PTB_MODE_STOP 1
`define PTB_MODE_OSC 2
`define PTB_MODE_ACTIVE 3
`define PTB_MODE_W 4

// reset values
`define PTB_RATE_RST 3'h0
`define PTB_EV_RST 3'h0

// divider chain length and the chain bit watched for each rate code
`define PTB_STAGES 15
`define PTB_TAP_0 4'hE
`define PTB_TAP_1 4'hC
`define PTB_TAP_2 4'hA
`define PTB_TAP_3 4'h6
`define PTB_TAP_4 4'h5
`define PTB_TAP_5 4'h4
`define PTB_TAP_6 4'h3
`define PTB_TAP_7 4'h2

`endif

/* hdl/ptb_divider.v */
`timescale 1ns/100ps
`include "ptb_regs.vh"

module ptb_divider #(
   parameter STAGES = `PTB_STAGES
) (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire advance,
   input wire [2:0] rate_select,
   output reg [STAGES-1:0] chain_count_r,
   output reg rollover_r
);

   // chain bit whose rise marks a rollover, four bits per rate code, code 0 lowest
   localparam [31:0] TAP_TABLE = {`PTB_TAP_7, `PTB_TAP_6, `PTB_TAP_5, `PTB_TAP_4,
      `PTB_TAP_3, `PTB_TAP_2, `PTB_TAP_1, `PTB_TAP_0};

   wire [STAGES-1:0] count_inc;
   wire [7:0] tap_rise;

   assign count_inc = chain_count_r + {{(STAGES-1){1'b0}}, 1'b1};

   // one rise detector per selectable tap; a tap bit first rises at half
   // its period after a restart from zero, then once every full period
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_tap
         localparam [3:0] TAP = TAP_TABLE[gi*4 +: 4];
         assign tap_rise[gi] = ~chain_count_r[TAP] & count_inc[TAP];
      end
   endgenerate

   // chain held at zero while stopped, counts one step per crystal tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_count_r <= {STAGES{1'b0}};
         rollover_r <= 1'b0;
      end else begin
         rollover_r <= run & advance & tap_rise[rate_select];
         if (!run) begin
            chain_count_r <= {STAGES{1'b0}};
         end else if (advance) begin
            chain_count_r <= count_inc;
         end
      end
   end

endmodule // ptb_divider

/* hdl/ptb_top.v */
// Overview of operation
// - tap rollover sets pending flag, read-only
// - rate field picks one of eight divisions
// - acknowledge bit always reads as zero
// - writing one acknowledges, zero does nothing
// - pending and enabled raises cpu request
// - reset clears the interrupt enable
// - stopped chain held at zero, restarts cleanly
// - reset clears run bit, chain zero
// - chain keeps counting in wait mode
// - no register access in wait or stop
// - stop counts only with oscillator kept running
// - enabled rollover in stop wakes device
// - first flag at half period, then full
// - fifteen stage chain on crystal clock
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ptb_regs.vh"

module ptb_top #(
   parameter STAGES = `PTB_STAGES
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire crystal_tick_clock,
   input wire wait_mode,
   input wire stop_mode,
   input wire osc_run_in_stop,
   output reg period_irq,
   output reg event_irq,
   output reg stop_wakeup
);

   // control register state
   reg divider_run_r;
   reg period_irq_enable_r;
   reg [2:0] rate_select_r;
   reg period_pending_flag_r;

   // event interrupt state
   reg [`PTB_EV_W-1:0] ev_status_r;
   reg [`PTB_EV_W-1:0] ev_enable_r;

   // crystal edge detect
   reg xtal_prev_r;

   // bus answer bookkeeping
   reg [31:0] read_nxt;
   reg err_nxt;
   reg addr_hit;

   wire xtal_rise;
   wire chain_active;
   wire rollover;
   wire [STAGES-1:0] chain_count;
   wire cpu_locked;
   wire bus_setup;
   wire bus_done;
   wire wr_fire;
   wire wr_ctrl;
   wire wr_ev_clr;
   wire wr_ev_en;
   wire ack_write;
   wire rate_misuse;
   wire [`PTB_EV_W-1:0] ev_set;
   wire [`PTB_EV_W-1:0] ev_clr;
   wire [2:0] wr_rate;
   wire pending_nxt;

   // crystal input is taken as synchronous to pclk; one tick per rising edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_prev_r <= 1'b0;
      end else begin
         xtal_prev_r <= crystal_tick_clock;
      end
   end

   assign xtal_rise = crystal_tick_clock & ~xtal_prev_r;

   // wait mode never gates the chain; stop does unless the oscillator
   // is kept alive, in which case the chain is the periodic wake source
   assign chain_active = divider_run_r & (~stop_mode | osc_run_in_stop);

   ptb_divider #(
      .STAGES(STAGES)
   ) u_divider (
      .pclk(pclk),
      .presetn(presetn),
      .run(divider_run_r),
      .advance(xtal_rise & chain_active),
      .rate_select(rate_select_r),
      .chain_count_r(chain_count),
      .rollover_r(rollover)
   );

   // apb phases; the answer is decided in setup and given one cycle later
   assign bus_setup = psel & ~penable;
   assign bus_done = psel & penable & pready;

   // the cpu is asleep in wait and stop, so its register port is dead
   assign cpu_locked = wait_mode | stop_mode;

   // writes land at the completing edge unless the answer was an error
   assign wr_fire = bus_done & pwrite & ~pslverr;
   assign wr_ctrl = wr_fire & (paddr == `PTB_OFF_CTRL);
   assign wr_ev_clr = wr_fire & (paddr == `PTB_OFF_EV_CLR);
   assign wr_ev_en = wr_fire & (paddr == `PTB_OFF_EV_EN);

   assign wr_rate = pwdata[`PTB_CTRL_RATE_HI:`PTB_CTRL_RATE_LO];
   assign ack_write = wr_ctrl & pwdata[`PTB_CTRL_ACK];

   // rate change while running is accepted but reported, since the
   // phase of the chain against the new tap is then undefined
   assign rate_misuse = wr_ctrl & divider_run_r & pwdata[`PTB_CTRL_RUN] & (wr_rate != rate_select_r);

   // control register; reset leaves the timebase stopped and quiet
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider_run_r <= 1'b0;
         period_irq_enable_r <= 1'b0;
         rate_select_r <= `PTB_RATE_RST;
      end else if (wr_ctrl) begin
         divider_run_r <= pwdata[`PTB_CTRL_RUN];
         period_irq_enable_r <= pwdata[`PTB_CTRL_IE];
         rate_select_r <= wr_rate;
      end
   end

   // pending flag: rollover sets, acknowledge clears, set wins a tie
   assign pending_nxt = rollover | (period_pending_flag_r & ~ack_write);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_pending_flag_r <= 1'b0;
      end else begin
         period_pending_flag_r <= pending_nxt;
      end
   end

   // sticky event bits for the event interrupt
   assign ev_set[`PTB_EV_ROLL] = rollover;
   assign ev_set[`PTB_EV_WAKE] = rollover & stop_mode & period_irq_enable_r;
   assign ev_set[`PTB_EV_MISUSE] = rate_misuse;
   assign ev_clr = wr_ev_clr ? pwdata[`PTB_EV_W-1:0] : {`PTB_EV_W{1'b0}};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_status_r <= `PTB_EV_RST;
         ev_enable_r <= `PTB_EV_RST;
      end else begin
         ev_status_r <= ev_set | (ev_status_r & ~ev_clr); // set beats clear
         if (wr_ev_en) begin
            ev_enable_r <= pwdata[`PTB_EV_W-1:0];
         end
      end
   end

   // read data and error decided from the setup-phase address
   always @* begin
      read_nxt = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         `PTB_OFF_CTRL: begin
            read_nxt[`PTB_CTRL_PEND] = period_pending_flag_r;
            read_nxt[`PTB_CTRL_RATE_HI:`PTB_CTRL_RATE_LO] = rate_select_r;
            read_nxt[`PTB_CTRL_ACK] = 1'b0;
            read_nxt[`PTB_CTRL_IE] = period_irq_enable_r;
            read_nxt[`PTB_CTRL_RUN] = divider_run_r;
         end
         `PTB_OFF_EV_STAT: begin
            read_nxt[`PTB_EV_W-1:0] = ev_status_r;
         end
         `PTB_OFF_EV_CLR: begin
            read_nxt = 32'h0000_0000; // write-only, reads zero
         end
         `PTB_OFF_EV_EN: begin
            read_nxt[`PTB_EV_W-1:0] = ev_enable_r;
         end
         `PTB_OFF_COUNT: begin
            read_nxt[STAGES-1:0] = chain_count;
         end
         `PTB_OFF_MODE: begin
            read_nxt[`PTB_MODE_WAIT] = wait_mode;
            read_nxt[`PTB_MODE_STOP] = stop_mode;
            read_nxt[`PTB_MODE_OSC] = osc_run_in_stop;
            read_nxt[`PTB_MODE_ACTIVE] = chain_active;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
      // locked or unmapped: error answer, zero data, no side effect
      err_nxt = ~addr_hit | cpu_locked;
      if (err_nxt) begin
         read_nxt = 32'h0000_0000;
      end
   end

   // bus answer: pready high in the first access cycle, so every
   // transfer is setup plus one access cycle with no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= bus_setup;
         if (bus_setup) begin
            pslverr <= err_nxt;
            prdata <= pwrite ? 32'h0000_0000 : read_nxt;
         end else begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
         end
      end
   end

   // registered interrupt and wake outputs, one cycle behind their cause
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_irq <= 1'b0;
         event_irq <= 1'b0;
         stop_wakeup <= 1'b0;
      end else begin
         period_irq <= period_pending_flag_r & period_irq_enable_r;
         event_irq <= |(ev_status_r & ev_enable_r);
         // high while stop_mode and the oscillator stay on and the enabled flag is pending; drops once stop_mode falls
         stop_wakeup <= stop_mode & osc_run_in_stop & period_pending_flag_r & period_irq_enable_r;
      end
   end

endmodule // ptb_top

/* test/ptb_top_asserts.sv */
`timescale 1ns/100ps
module ptb_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire wait_mode,
   input wire stop_mode,
   input wire osc_run_in_stop,
   input wire period_irq,
   input wire stop_wakeup
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus phases and the frozen stop window
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd_ctrl;
      pready && !pslverr && !pwrite && paddr == 8'h00;
   endsequence
   // five cycles lets a tick taken just before stop drain out
   sequence s_frozen;
      (stop_mode && !osc_run_in_stop) [*5];
   endsequence
   a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
      else $error("ready not a single cycle after setup");
   a_locked_bus: assert property (s_setup ##0 (wait_mode || stop_mode) |=> pslverr && prdata == 32'h0)
      else $error("access in low power not refused");
   a_ack_reads_zero: assert property (s_rd_ctrl |-> !prdata[3])
      else $error("acknowledge bit read back as one");
   a_irq_matches: assert property (s_rd_ctrl |-> period_irq == (prdata[7] && prdata[2]))
      else $error("interrupt disagrees with flag and enable");
   a_reset_quiet: assert property ($rose(presetn) |-> !period_irq && !stop_wakeup)
      else $error("outputs active after reset");
   a_wake_in_stop: assert property (stop_wakeup |-> $past(stop_mode) && $past(osc_run_in_stop))
      else $error("wakeup outside oscillator stop");
   a_wake_irq: assert property (stop_wakeup |-> period_irq)
      else $error("wakeup without enabled flag");
   a_stop_frozen: assert property (s_frozen |-> !$rose(period_irq))
      else $error("flag set with oscillator stopped");
endmodule // ptb_chk

bind ptb_top ptb_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
   .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop), .period_irq(period_irq), .stop_wakeup(stop_wakeup));

/* test/ptb_top_tb.sv */
`timescale 1ns/100ps
module ptb_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic xtal = 0, xen = 0, wt = 0, st = 0, osc = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic [2:0] pr = 3'h0;
   wire [31:0] prdata;
   wire pready, pslverr, period_irq, event_irq, stop_wakeup;
   int bad_count = 0, tests_run = 0, ticks = 0, t0, d, i;
   int divs[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
   ptb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_tick_clock(xtal),
      .wait_mode(wt), .stop_mode(st), .osc_run_in_stop(osc), .period_irq(period_irq), .event_irq(event_irq),
      .stop_wakeup(stop_wakeup));
   initial forever #12.5 pclk = ~pclk;
   // crystal rises every second pclk, frozen while xen is low
   always @(posedge pclk) if (xen) begin
      xtal <= ~xtal;
      if (!xtal) ticks <= ticks + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_irq();
      int n = 0;
      // a request just acknowledged still shows for two edges
      repeat (2) @(posedge pclk);
      while (period_irq !== 1'b1 && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 70000) bad_count++;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, well past the longest rate sweep
   initial begin
      #(25.0 * 95000);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h00, 0);
      check(rd, 0);
      apb(0, 8'h10, 0);
      check(rd, 0);
      // each rate row: first flag near half, then the full division for every rate but rate 0
      for (i = 0; i < 8; i++) begin
         xen <= 1'b0;
         apb(1, 8'h00, {25'h0, pr, 4'hC});
         apb(1, 8'h00, {25'h0, i[2:0], 4'h6});
         pr = i[2:0];
         t0 = ticks;
         xen <= 1'b1;
         wait_irq();
         d = ticks - t0 - divs[i] / 2;
         check(32'(d >= 0 && d <= 4), 1);
         t0 = ticks;
         apb(0, 8'h00, 0);
         check(rd[7:0], {1'b1, i[2:0], 4'h6});
         if (divs[i] < 9000) begin
            apb(1, 8'h00, {25'h0, i[2:0], 4'hE});
            wait_irq();
            check(ticks - t0, divs[i]);
         end
      end
      xen <= 1'b0;
      apb(1, 8'h00, 32'h76);
      apb(0, 8'h00, 0);
      check(rd[7], 1);
      apb(1, 8'h00, 32'h7E);
      apb(0, 8'h00, 0);
      check(rd[7], 0);
      // flag without enable stays silent
      apb(1, 8'h00, 32'h7A);
      xen <= 1'b1;
      repeat (40) @(posedge pclk);
      check(period_irq, 0);
      apb(0, 8'h00, 0);
      check(rd[7], 1);
      apb(1, 8'h00, 32'h78);
      apb(0, 8'h10, 0);
      check(rd, 0);
      // wait mode: bus locked, chain still running
      apb(1, 8'h00, 32'h76);
      wt <= 1'b1;
      apb(1, 8'h00, 0);
      check(err, 1);
      check(rd, 0);
      wait_irq();
      check(period_irq, 1);
      wt <= 1'b0;
      xen <= 1'b0;
      apb(0, 8'h00, 0);
      check(rd[2:1], 2'h3);
      // stop mode with and without the oscillator; the read above drains a tick in flight
      apb(1, 8'h00, 32'h7E);
      st <= 1'b1;
      xen <= 1'b1;
      repeat (60) @(posedge pclk);
      check(period_irq, 0);
      osc <= 1'b1;
      wait_irq();
      check(stop_wakeup, 1);
      st <= 1'b0;
      osc <= 1'b0;
      xen <= 1'b0;
      // event block: masked, enabled, cleared, then unmapped access
      apb(0, 8'h04, 0);
      check({event_irq, rd[0]}, 2'h1);
      apb(1, 8'h0C, 1);
      repeat (2) @(posedge pclk);
      check(event_irq, 1);
      apb(1, 8'h08, 7);
      repeat (2) @(posedge pclk);
      check(event_irq, 0);
      apb(0, 8'h18, 0);
      check(err, 1);
      check(rd, 0);
      // rate change while running is flagged in event bit 2
      apb(1, 8'h00, 32'h06);
      apb(0, 8'h04, 0);
      check(rd[2:0], 3'h4);
      // timebase stopped before sleeping stays at zero through stop
      apb(1, 8'h00, 32'h7C);
      st <= 1'b1;
      osc <= 1'b1;
      xen <= 1'b1;
      repeat (40) @(posedge pclk);
      check(period_irq, 0);
      check(stop_wakeup, 0);
      st <= 1'b0;
      osc <= 1'b0;
      apb(0, 8'h10, 0);
      check(rd, 0);
      // reset in mid-run clears run, enable and chain
      apb(1, 8'h00, 32'h76);
      repeat (20) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h00, 0);
      check(rd, 0);
      apb(0, 8'h10, 0);
      check(rd, 0);
      check(period_irq, 0);
      summarize();
   end
endmodule // ptb_top_tb
